// *** hw/cc_tx_pkg.sv ***
`default_nettype none
package cc_tx_pkg;
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned LINE_HZ         = 64_000;
	localparam int unsigned SUB_PER_BIT     = 8;
	localparam int unsigned SUB_HZ          = LINE_HZ * SUB_PER_BIT;
	localparam logic [24:0] NCO_MOD         = 25'(CLK_HZ);
	localparam logic [24:0] NCO_STEP        = 25'(SUB_HZ);
	localparam logic [2:0]  SUB_LAST        = 3'(SUB_PER_BIT - 1);
	localparam logic [2:0]  HIGH_SUBS_58    = 3'h5;
	localparam logic [2:0]  HIGH_SUBS_50    = 3'h4;
	localparam logic [2:0]  VIOL_BIT        = 3'h7;
	localparam int unsigned LOW_PERIOD_BITS = 160;
	localparam int unsigned BITS_PER_BYTE   = 8;
	localparam logic [4:0]  LOW_LAST        = 5'(LOW_PERIOD_BITS / BITS_PER_BYTE - 1);
	localparam logic [4:0]  LOW_REMOVE_SLOT = 5'h00;
	localparam logic        DUTY_58         = 1'b1;
	localparam logic        FORMAT_CC       = 1'b0;
	localparam int unsigned BYTE_WINDOW_US  = 500;
	localparam int unsigned LOW_WINDOW_MS   = 5;
	localparam int unsigned BYTE_WINDOW_CYC = BYTE_WINDOW_US * (CLK_HZ / 1_000_000);
	localparam int unsigned LOW_WINDOW_CYC  = LOW_WINDOW_MS * (CLK_HZ / 1_000);
	typedef enum logic [1:0] {
		REF_OTHER     = 2'h0,
		REF_INPUT_ONE = 2'h1,
		REF_INPUT_TWO = 2'h3
	} ref_sel_t;
endpackage
`default_nettype wire

// *** hw/cc_marker_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface cc_marker_if;
	logic bpvSeen;
	logic removedSeen;
	logic byteMissing;
	logic lowMissing;
	modport mon (output bpvSeen, output removedSeen, output byteMissing, output lowMissing);
	modport use_side (input bpvSeen, input removedSeen, input byteMissing, input lowMissing);
endinterface
`default_nettype wire

// *** hw/cc_marker_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module cc_marker_monitor #(
	parameter int unsigned BYTE_WINDOW = cc_tx_pkg::BYTE_WINDOW_CYC,
	parameter int unsigned LOW_WINDOW  = cc_tx_pkg::LOW_WINDOW_CYC
) (
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire logic     violIn,
	input  wire logic     removedIn,
	cc_marker_if.mon      mk
);
	localparam int unsigned BW = $clog2(BYTE_WINDOW + 1);
	localparam int unsigned LW = $clog2(LOW_WINDOW + 1);

	typedef struct packed {
		logic [2:0]    vSync;
		logic [2:0]    rSync;
		logic          vLvl;
		logic          rLvl;
		logic [BW-1:0] byteCnt;
		logic [LW-1:0] lowCnt;
		logic          byteMissing;
		logic          lowMissing;
		logic          bpvSeen;
		logic          removedSeen;
	} mon_state_t;

	mon_state_t state_reg;
	mon_state_t state_next;

	always_comb
	begin
		state_next = state_reg;
		state_next.vSync = {state_reg.vSync[1:0], violIn};
		state_next.rSync = {state_reg.rSync[1:0], removedIn};
		// level changes only once stages two and three agree
		if (state_reg.vSync[1] == state_reg.vSync[2])
			state_next.vLvl = state_reg.vSync[2];
		if (state_reg.rSync[1] == state_reg.rSync[2])
			state_next.rLvl = state_reg.rSync[2];
		state_next.bpvSeen = state_next.vLvl & ~state_reg.vLvl;
		state_next.removedSeen = state_next.rLvl & ~state_reg.rLvl;
		// a marker in the same cycle as window expiry keeps the flag clear
		if (state_next.bpvSeen)
		begin
			state_next.byteCnt = '0;
			state_next.byteMissing = 1'b0;
		end
		else if (state_reg.byteCnt == BW'(BYTE_WINDOW - 1))
			state_next.byteMissing = 1'b1;
		else
			state_next.byteCnt = state_reg.byteCnt + BW'(1);
		if (state_next.removedSeen)
		begin
			state_next.lowCnt = '0;
			state_next.lowMissing = 1'b0;
		end
		else if (state_reg.lowCnt == LW'(LOW_WINDOW - 1))
			state_next.lowMissing = 1'b1;
		else
			state_next.lowCnt = state_reg.lowCnt + LW'(1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign mk.bpvSeen     = state_reg.bpvSeen;
	assign mk.removedSeen = state_reg.removedSeen;
	assign mk.byteMissing = state_reg.byteMissing;
	assign mk.lowMissing  = state_reg.lowMissing;
endmodule
`default_nettype wire

// *** hw/composite_clock_transmitter.sv ***
`timescale 1ns/100ps
`default_nettype none
// Contract
// - output enable drives or releases the differential output pair
// - duty select picks half-period or five-eighths pulse width
// - suppress-byte-marker removes the violation every eighth cycle
// - align output violations to selected composite input violations
// - low-rate enable removes one violation every 160 cycles
// - align low-rate removals to those of the selected input
// - otherwise derive low-rate removal by dividing own byte markers
// - low-rate enable ignored while byte marker suppressed
// - bipolar AMI, return to zero, five-eighths default form
// - 64kHz line rate with byte-marking violation at 8kHz
// - input byte marker missing after 500us without violation
// - input low-rate marker missing after 5ms without removal
module composite_clock_transmitter #(
	parameter int unsigned BYTE_WINDOW = cc_tx_pkg::BYTE_WINDOW_CYC,
	parameter int unsigned LOW_WINDOW  = cc_tx_pkg::LOW_WINDOW_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 ccOutEnable,
	input  wire logic                 ccDutySelect,
	input  wire logic                 suppressByteMarker,
	input  wire logic                 lowRateMarkerEnable,
	input  wire cc_tx_pkg::ref_sel_t  refSelect,
	input  wire logic [1:0]           inputFormatSelect,
	input  wire logic [1:0]           ccInViolation,
	input  wire logic [1:0]           ccInRemoved,
	output logic                      ccOutPositive,
	output logic                      ccOutNegative,
	output logic                      ccOutDriveEnable,
	output logic [1:0]                inputByteMarkerMissing,
	output logic [1:0]                inputLowRateMarkerMissing
);
	// nco is the phase accumulator of the sub-bit enable; lowCnt counts bytes of the low-rate period
	typedef struct packed {
		logic [24:0] nco;
		logic [2:0]  sub;
		logic [2:0]  bitCnt;
		logic [4:0]  lowCnt;
		logic        lastPol;
		logic        outPos;
		logic        outNeg;
		logic        drive;
	} tx_state_t;

	tx_state_t state_reg;
	tx_state_t state_next;

	// both monitors always run, so their flags are current when the reference changes
	cc_marker_if mk [2] ();

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_mon
			cc_marker_monitor #(
				.BYTE_WINDOW (BYTE_WINDOW),
				.LOW_WINDOW  (LOW_WINDOW)
			) u_mon (
				.clk       (clk),
				.rst       (rst),
				.violIn    (ccInViolation[gi]),
				.removedIn (ccInRemoved[gi]),
				.mk        (mk[gi])
			);
		end
	endgenerate

	logic [1:0] bpvSeen;
	logic [1:0] removedSeen;
	logic [1:0] byteMissing;
	logic [1:0] lowMissing;
	assign bpvSeen     = {mk[1].bpvSeen, mk[0].bpvSeen};
	assign removedSeen = {mk[1].removedSeen, mk[0].removedSeen};
	assign byteMissing = {mk[1].byteMissing, mk[0].byteMissing};
	assign lowMissing  = {mk[1].lowMissing, mk[0].lowMissing};
	assign inputByteMarkerMissing    = byteMissing;
	assign inputLowRateMarkerMissing = lowMissing;

	// one-hot pick of the selected composite input, zero when none
	function automatic logic [1:0] refPick(input cc_tx_pkg::ref_sel_t sel);
		logic [1:0] pick;
		pick = 2'h0;
		if (sel == cc_tx_pkg::REF_INPUT_ONE)
			pick = 2'h1;
		else if (sel == cc_tx_pkg::REF_INPUT_TWO)
			pick = 2'h2;
		return pick;
	endfunction

	// high sub-phases per bit for the chosen duty form
	function automatic logic [2:0] highSubsFor(input logic dutySel);
		logic [2:0] n;
		n = cc_tx_pkg::HIGH_SUBS_50;
		if (dutySel == cc_tx_pkg::DUTY_58)
			n = cc_tx_pkg::HIGH_SUBS_58;
		return n;
	endfunction

	// an input in plain clock format carries no markers to align to
	logic [1:0] inIsCc;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_fmt
			assign inIsCc[gi] = (inputFormatSelect[gi] == cc_tx_pkg::FORMAT_CC);
		end
	endgenerate

	logic [1:0] pick;
	logic       refIsCc;
	logic       align8;
	logic       align400;
	logic       hit8;
	logic       hit400;
	logic       lowActive;

	// alignment needs the picked input in composite form with its markers present
	always_comb
	begin
		pick = refPick(refSelect);
		refIsCc = |(pick & inIsCc);
		align8 = refIsCc && !(|(pick & byteMissing));
		align400 = align8 && !(|(pick & lowMissing));
		hit8 = align8 && (|(pick & bpvSeen));
		lowActive = lowRateMarkerEnable && !suppressByteMarker;
		hit400 = align400 && lowActive && (|(pick & removedSeen));
	end

	logic       subTick;
	logic       newBit;
	logic       isViol;
	logic       pol;
	logic [2:0] highSubs;
	logic [25:0] ncoSum;
	logic       byteSlot;
	logic       lowSlot;

	always_comb
	begin
		state_next = state_reg;
		subTick = 1'b0;
		newBit = 1'b0;
		isViol = 1'b0;
		pol = state_reg.lastPol;
		byteSlot = 1'b0;
		lowSlot = 1'b0;
		// fractional divider: 512kHz sub-bit enable from 25MHz, no drift
		ncoSum = {1'b0, state_reg.nco} + {1'b0, cc_tx_pkg::NCO_STEP};
		if (ncoSum >= {1'b0, cc_tx_pkg::NCO_MOD})
		begin
			state_next.nco = 25'(ncoSum - {1'b0, cc_tx_pkg::NCO_MOD});
			subTick = 1'b1;
		end
		else
			state_next.nco = ncoSum[24:0];
		if (subTick)
		begin
			state_next.sub = state_reg.sub + 3'h1;
			if (state_reg.sub == cc_tx_pkg::SUB_LAST)
			begin
				newBit = 1'b1;
				state_next.bitCnt = state_reg.bitCnt + 3'h1;
				if (state_reg.bitCnt == cc_tx_pkg::VIOL_BIT)
				begin
					// byte divider yields the low-rate slot when not aligned
					if (state_reg.lowCnt == cc_tx_pkg::LOW_LAST)
						state_next.lowCnt = 5'h00;
					else
						state_next.lowCnt = state_reg.lowCnt + 5'h01;
				end
			end
		end
		// an input marker restarts the bit at once as the byte-marker bit, so the jump can reach 7 bits
		if (hit8 || hit400)
		begin
			state_next.nco = '0;
			state_next.sub = 3'h0;
			state_next.bitCnt = cc_tx_pkg::VIOL_BIT;
			newBit = 1'b1;
			if (hit400)
				state_next.lowCnt = cc_tx_pkg::LOW_REMOVE_SLOT;
		end
		if (newBit)
		begin
			byteSlot = (state_next.bitCnt == cc_tx_pkg::VIOL_BIT);
			// the removal slot falls on a byte marker, so it exists only with them
			lowSlot = lowActive && (state_next.lowCnt == cc_tx_pkg::LOW_REMOVE_SLOT);
			isViol = byteSlot && !suppressByteMarker && !lowSlot;
			pol = isViol ? state_reg.lastPol : ~state_reg.lastPol;
			state_next.lastPol = pol;
		end
		highSubs = highSubsFor(ccDutySelect);
		// a released pair is held low too, so re-enabling never replays a stale mark
		state_next.outPos = 1'b0;
		state_next.outNeg = 1'b0;
		// return to zero after the high sub-phases of every bit
		if (ccOutEnable && (state_next.sub < highSubs))
		begin
			state_next.outPos = pol;
			state_next.outNeg = !pol;
		end
		state_next.drive = ccOutEnable;
	end

	// every output is a flip-flop so the line never sees decode glitches
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign ccOutPositive    = state_reg.outPos;
	assign ccOutNegative    = state_reg.outNeg;
	assign ccOutDriveEnable = state_reg.drive;
endmodule
`default_nettype wire

// *** testbench/cc_tx_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module cc_tx_assertions #(
	parameter int unsigned BYTE_WINDOW = cc_tx_pkg::BYTE_WINDOW_CYC
) (
	input wire logic                clk,
	input wire logic                rst,
	input wire logic                ccOutEnable,
	input wire logic                ccDutySelect,
	input wire cc_tx_pkg::ref_sel_t refSelect,
	input wire logic [1:0]          ccInViolation,
	input wire logic                ccOutPositive,
	input wire logic                ccOutNegative,
	input wire logic                ccOutDriveEnable,
	input wire logic [1:0]          inputByteMarkerMissing
);
	logic        mark, markQ, drvQ, clean, freeRun, markEnd;
	logic [9:0]  hiCnt, gap;
	logic [15:0] quiet;
	assign mark = ccOutPositive | ccOutNegative;
	assign freeRun = refSelect == cc_tx_pkg::REF_OTHER;
	// a pulse cut by enabling mid-mark is not judged
	assign markEnd = clean && markQ && !mark && ccOutEnable && freeRun;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			markQ <= 1'b0;
			drvQ  <= 1'b0;
			clean <= 1'b0;
			hiCnt <= 10'h000;
			gap   <= 10'h3FF;
			quiet <= 16'h0000;
		end
		else
		begin
			markQ <= mark;
			drvQ  <= ccOutDriveEnable;
			clean <= (mark && !markQ) ? drvQ : clean;
			hiCnt <= mark ? hiCnt + 10'h001 : 10'h000;
			// saturates so a released pair or a pulse cut by enabling never yields a bogus interval
			gap   <= (!ccOutDriveEnable || (mark && !markQ && !drvQ)) ? 10'h3FF
				: (mark && !markQ) ? 10'h001 : (&gap) ? gap : gap + 10'h001;
			quiet <= ccInViolation[0] ? 16'h0000 : quiet + 16'h0001;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	chk_idle_off: assert property (!ccOutEnable |=> !mark) else $error("pair active when off");
	chk_drive_follows: assert property (!$past(rst) |-> ccOutDriveEnable == $past(ccOutEnable))
		else $error("drive enable wrong");
	chk_lines_apart: assert property (!(ccOutPositive && ccOutNegative)) else $error("both lines high");
	chk_width_long: assert property (markEnd && ccDutySelect |-> hiCnt inside {[238:247]})
		else $error("long pulse width");
	chk_width_half: assert property (markEnd && !ccDutySelect |-> hiCnt inside {[190:198]})
		else $error("half pulse width");
	chk_bit_spacing: assert property (mark && !markQ && freeRun && !(&gap) |-> gap inside {[389:392]})
		else $error("bit spacing");
	chk_missing_set: assert property ($rose(inputByteMarkerMissing[0])
		|-> quiet inside {[BYTE_WINDOW - 12:BYTE_WINDOW + 4]}) else $error("missing flag early or late");
	chk_missing_clear: assert property ($rose(ccInViolation[0]) |-> ##[4:8] !inputByteMarkerMissing[0])
		else $error("missing flag kept");
	cover property (markEnd && !ccDutySelect);
	cover property ($rose(inputByteMarkerMissing[0]));
	cover property (mark && !markQ && !freeRun);
endmodule
bind composite_clock_transmitter cc_tx_assertions #(.BYTE_WINDOW(BYTE_WINDOW)) chk (
	.clk(clk), .rst(rst), .ccOutEnable(ccOutEnable), .ccDutySelect(ccDutySelect), .refSelect(refSelect),
	.ccInViolation(ccInViolation), .ccOutPositive(ccOutPositive), .ccOutNegative(ccOutNegative),
	.ccOutDriveEnable(ccOutDriveEnable), .inputByteMarkerMissing(inputByteMarkerMissing));
`default_nettype wire

// *** testbench/cc_line_receiver.sv ***
`timescale 1ns/100ps
`default_nettype none
module cc_line_receiver (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic linePos,
	input  wire logic lineNeg,
	input  wire logic lineDriven,
	output int        nMarks,
	output int        nViol,
	output int        nRemoved,
	output int        nBad
);
	logic markQ, lastPos, primed;
	int   since;
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			nMarks = 0;
			nViol = 0;
			nRemoved = 0;
			nBad = 0;
			since = -64;
			markQ = 1'b0;
			lastPos = 1'b0;
			primed = 1'b0;
		end
		else
		begin
			// a released pair breaks the mark history
			if (!lineDriven)
			begin
				since = -64;
				primed = 1'b0;
			end
			if ((linePos | lineNeg) && !markQ)
			begin
				nMarks++;
				// first mark after reset or release has no polarity to compare with
				if (primed && linePos === lastPos)
				begin
					nViol++;
					if (since == 15)
						nRemoved++;
					else if (since >= 0 && since != 7)
						nBad++;
					since = 0;
				end
				else
					since++;
				lastPos = linePos;
				primed = 1'b1;
			end
			if (linePos && lineNeg)
				nBad++;
			markQ = linePos | lineNeg;
		end
	end
endmodule
`default_nettype wire

// *** testbench/tb_composite_clock_transmitter.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_composite_clock_transmitter;
	logic                clk, rst, en, duty, supp, lowEn, pos, neg, drv;
	logic [1:0]          fmt, vin, rin, byteMiss, lowMiss;
	cc_tx_pkg::ref_sel_t refSel;
	int                  nMarks, nViol, nRem, nBad, nFail, cmpCount, cycles, v, m;
	composite_clock_transmitter #(.BYTE_WINDOW(4000), .LOW_WINDOW(8000)) uut (
		.clk(clk), .rst(rst), .ccOutEnable(en), .ccDutySelect(duty), .suppressByteMarker(supp),
		.lowRateMarkerEnable(lowEn), .refSelect(refSel), .inputFormatSelect(fmt), .ccInViolation(vin),
		.ccInRemoved(rin), .ccOutPositive(pos), .ccOutNegative(neg), .ccOutDriveEnable(drv),
		.inputByteMarkerMissing(byteMiss), .inputLowRateMarkerMissing(lowMiss));
	cc_line_receiver far (.clk(clk), .rst(rst), .linePos(pos), .lineNeg(neg), .lineDriven(drv),
		.nMarks(nMarks), .nViol(nViol), .nRemoved(nRem), .nBad(nBad));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmpCount++;
		if (seen !== exp)
		begin
			nFail++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic bits(input int n);
		repeat (n * 391) @(negedge clk);
	endtask
	task automatic end_of_test;
		$display("mismatches %0d comparisons %0d", nFail, cmpCount);
		if (nFail == 0 && cmpCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic t_default;
		v = nViol;
		bits(12);
		check(32'(nViol - v >= 1), 32'h1, "violations");
		check(32'(byteMiss), 32'h3, "byte missing");
		check(32'(drv), 32'h1, "drive");
	endtask
	task automatic t_half;
		en = 1'b0;
		duty = 1'b0;
		bits(1);
		check(32'({pos, neg, drv}), 32'h0, "released pair");
		en = 1'b1;
		v = nMarks;
		bits(6);
		check(32'(nMarks - v >= 5), 32'h1, "marks");
	endtask
	task automatic t_suppress;
		supp = 1'b1;
		lowEn = 1'b1;
		v = nViol;
		bits(12);
		check(32'(nViol - v), 32'h0, "suppressed violations");
		check(32'(lowMiss), 32'h3, "low missing");
	endtask
	task automatic t_lowrate;
		en = 1'b0;
		supp = 1'b0;
		bits(1);
		en = 1'b1;
		v = nRem;
		bits(172);
		check(32'(nRem - v >= 1 && nRem - v <= 2), 32'h1, "removals");
		check(32'(nBad), 32'h0, "pattern faults");
	endtask
	task automatic t_align;
		lowEn = 1'b0;
		refSel = cc_tx_pkg::REF_INPUT_ONE;
		fmt = 2'h2;
		// every pulse pulls the phase; the violation after the last one is judged
		repeat (3)
		begin
			wait (!(pos | neg));
			wait (pos | neg);
			repeat (300) @(negedge clk);
			v = nViol;
			vin[0] = 1'b1;
			repeat (12) @(negedge clk);
			vin[0] = 1'b0;
		end
		check(32'(nViol - v), 32'h1, "aligned violation");
		check(32'(byteMiss[0]), 32'h0, "byte missing cleared");
		// a removal marker on the aligned input forces a removed slot at once
		lowEn = 1'b1;
		wait (!(pos | neg));
		wait (pos | neg);
		repeat (300) @(negedge clk);
		v = nViol;
		m = nMarks;
		rin[0] = 1'b1;
		repeat (12) @(negedge clk);
		rin[0] = 1'b0;
		check(32'(nMarks - m), 32'h1, "aligned removal mark");
		check(32'(nViol - v), 32'h0, "aligned removal");
		check(32'(lowMiss[0]), 32'h0, "low missing cleared");
	endtask
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 95000)
		begin
			nFail++;
			end_of_test();
		end
	end
	initial
	begin
		{rst, en, duty, supp, lowEn, fmt, vin, rin} = 11'h730;
		refSel = cc_tx_pkg::REF_OTHER;
		repeat (8) @(negedge clk);
		check(32'({pos, neg, drv, byteMiss, lowMiss}), 32'h0, "reset outputs");
		rst = 1'b0;
		t_default();
		t_half();
		t_suppress();
		t_lowrate();
		t_align();
		end_of_test();
	end
endmodule
`default_nettype wire
